// ---- rtl/ppaf_pkg.sv ----
// Package for the port pin block: widths, reset values, build variants.
// Assumes nothing of its surroundings; used by ppaf_port and by the bench.
package ppaf_pkg;

  // ------------------------------------------------------------
  // Port widths and bit positions
  // ------------------------------------------------------------
  localparam int SEL_W = 4;
  localparam int IRQ_W = 7;
  localparam int IRQ_LSB = 9;
  localparam int TIN_W = 2;
  localparam int TIN_B_BIT = 0;
  localparam int TIN_A_BIT = 1;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [3:0] SEL_DIR_RST = 4'h0;
  localparam logic [3:0] SEL_OUT_RST = 4'hF;
  localparam logic [6:0] IRQ_DIR_RST = 7'h00;
  localparam logic [6:0] IRQ_OUT_RST = 7'h7F;
  localparam logic [3:0] SEL_N_RST = 4'hF;
  localparam logic [3:0] SEL_OE_RST = 4'h0;
  localparam logic [3:0] SEL_PIN_RST = 4'h0;
  localparam logic [6:0] IRQ_OE_RST = 7'h00;
  localparam logic [6:0] IRQ_PIN_RST = 7'h00;
  localparam logic [6:0] FAST_IRQ_RST = 7'h00;
  localparam logic [1:0] TIN_PIN_RST = 2'h0;
  localparam logic UPDOWN_RST = 1'h0;

  // ------------------------------------------------------------
  // Build variants
  // ------------------------------------------------------------
  typedef enum {PPAF_FULL, PPAF_MID, PPAF_MIN} ppaf_variant_t;

  // Number of select outputs per variant
  function automatic int sel_count(ppaf_variant_t v);
    case (v)
      PPAF_FULL: sel_count = 4;
      PPAF_MID: sel_count = 2;
      default: sel_count = 0;
    endcase
  endfunction

  // Number of fast interrupt inputs per variant
  function automatic int irq_count(ppaf_variant_t v);
    case (v)
      PPAF_FULL: irq_count = 7;
      default: irq_count = 4;
    endcase
  endfunction

endpackage

// ---- rtl/ppaf_port.sv ----
// Port pin logic for the select, interrupt and timer-input ports.
// Assumes CPU-side latches are written synchronously to CLK_I and that
// pad tristating is resolved outside from the output enables.
// Reduced builds keep the pins but mask the missing alternates.
//
// Overview of operation
// - Select port: four pins, per-pin direction
// - Input pins have output driver off unless a select alternate is on
// - Select pins carry active-low selects by variant
// - Interrupt port: seven pins, per-pin direction
// - Interrupt pins feed fast interrupts by variant
// - Timer-input port: two pins, input only
// - Pin 14 gives timer b direction
// - Pin 15 gives timer a direction
// - Timer direction routing is a build option
`timescale 1ns/1ps

module ppaf_port #(
  parameter ppaf_pkg::ppaf_variant_t VARIANT = ppaf_pkg::PPAF_FULL
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Select port latches from the CPU
  input wire logic [3:0] SEL_DIR_WDATA_I,
  input wire logic SEL_DIR_WE_I,
  input wire logic [3:0] SEL_OUT_WDATA_I,
  input wire logic SEL_OUT_WE_I,
  input wire logic [3:0] SEL_ALT_EN_I,
  input wire logic [3:0] SEL_N_I,
  // Select port pads
  input wire logic [3:0] SEL_PAD_I,
  output logic [3:0] SEL_PAD_O,
  output logic [3:0] SEL_PAD_OE_O,
  output logic [3:0] SEL_PIN_O,
  // Interrupt port latches from the CPU
  input wire logic [6:0] IRQ_DIR_WDATA_I,
  input wire logic IRQ_DIR_WE_I,
  input wire logic [6:0] IRQ_OUT_WDATA_I,
  input wire logic IRQ_OUT_WE_I,
  // Interrupt port pads, bits 9 to 15
  input wire logic [15:9] IRQ_PAD_I,
  output logic [15:9] IRQ_PAD_O,
  output logic [15:9] IRQ_PAD_OE_O,
  output logic [15:9] IRQ_PIN_O,
  output logic [7:1] FAST_IRQ_IN_O,
  // Timer-input port pads, bits 14 and 15
  input wire logic [15:14] TIN_PAD_I,
  output logic [15:14] TIN_PIN_O,
  output logic TIMER_B_UPDOWN_IN_O,
  output logic TIMER_A_UPDOWN_IN_O,
  // Latch readback
  output logic [3:0] SEL_DIR_O,
  output logic [6:0] IRQ_DIR_O
);

  // ------------------------------------------------------------
  // Variant masks
  // ------------------------------------------------------------
  localparam int NSEL = ppaf_pkg::sel_count(VARIANT);
  localparam int NIRQ = ppaf_pkg::irq_count(VARIANT);
  localparam bit TIMER_ROUTE = (VARIANT != ppaf_pkg::PPAF_MIN);

  logic [3:0] sel_mask;
  logic [6:0] irq_mask;

  // Only built-in select and interrupt channels may act
  // Masks are constants, so unused channels cost no logic
  genvar g;
  generate
    for (g = 0; g < ppaf_pkg::SEL_W; g++)
    begin : g_selm
      assign sel_mask[g] = (g < NSEL);
    end
    for (g = 0; g < ppaf_pkg::IRQ_W; g++)
    begin : g_irqm
      assign irq_mask[g] = (g < NIRQ);
    end
  endgenerate

  // ------------------------------------------------------------
  // Direction and output latches
  // ------------------------------------------------------------
  logic [3:0] sel_dir, next_sel_dir, sel_out, next_sel_out;
  logic [6:0] irq_dir, next_irq_dir, irq_out, next_irq_out;

  // Software writes; one direction bit per pin
  always_comb
  begin
    next_sel_dir = SEL_DIR_WE_I ? SEL_DIR_WDATA_I : sel_dir;
    next_sel_out = SEL_OUT_WE_I ? SEL_OUT_WDATA_I : sel_out;
    next_irq_dir = IRQ_DIR_WE_I ? IRQ_DIR_WDATA_I : irq_dir;
    next_irq_out = IRQ_OUT_WE_I ? IRQ_OUT_WDATA_I : irq_out;
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sel_dir <= ppaf_pkg::SEL_DIR_RST;
      sel_out <= ppaf_pkg::SEL_OUT_RST;
      irq_dir <= ppaf_pkg::IRQ_DIR_RST;
      irq_out <= ppaf_pkg::IRQ_OUT_RST;
    end
    else
    begin
      sel_dir <= next_sel_dir;
      sel_out <= next_sel_out;
      irq_dir <= next_irq_dir;
      irq_out <= next_irq_out;
    end
  end

  // ------------------------------------------------------------
  // Select port pad drive and readback
  // ------------------------------------------------------------
  logic [3:0] next_sel_pad, next_sel_oe, next_sel_pin;

  // Select overrides latch; an alternate select forces the driver on.
  // Software may leave the direction bit at input: the select still
  // reaches the board, so a memory is never left without its enable.
  always_comb
  begin
    next_sel_pad = sel_out;
    next_sel_oe = sel_dir;
    for (int i = 0; i < ppaf_pkg::SEL_W; i++)
    begin
      if (SEL_ALT_EN_I[i] && sel_mask[i])
      begin
        next_sel_pad[i] = SEL_N_I[i];
        next_sel_oe[i] = 1'b1;
      end
    end
    // Pad level read back whatever the direction
    next_sel_pin = SEL_PAD_I;
  end

  // Registered drive; costs one cycle but the pad never sees a decode glitch
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      SEL_PAD_O <= ppaf_pkg::SEL_OUT_RST;
      SEL_PAD_OE_O <= ppaf_pkg::SEL_OE_RST; // Driver off: pins start as inputs
      SEL_PIN_O <= ppaf_pkg::SEL_PIN_RST;
      SEL_DIR_O <= ppaf_pkg::SEL_DIR_RST;
    end
    else
    begin
      SEL_PAD_O <= next_sel_pad;
      SEL_PAD_OE_O <= next_sel_oe;
      SEL_PIN_O <= next_sel_pin;
      SEL_DIR_O <= next_sel_dir; // Readback in step with the latch
    end
  end

  // ------------------------------------------------------------
  // Interrupt port pad drive and fast inputs
  // ------------------------------------------------------------
  logic [6:0] next_irq_pad, next_irq_oe, next_irq_pin, next_fast_irq;

  // Interrupt pads have no alternate output; the latches drive them.
  // Fast inputs read the pin level whatever the direction, so software
  // can raise its own interrupt by driving an output pin.
  always_comb
  begin
    next_irq_pad = irq_out;
    next_irq_oe = irq_dir;
    next_irq_pin = IRQ_PAD_I;
    next_fast_irq = IRQ_PAD_I & irq_mask;
  end

  // Registered; the interrupt controller sees each level one cycle late
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      IRQ_PAD_O <= ppaf_pkg::IRQ_OUT_RST;
      IRQ_PAD_OE_O <= ppaf_pkg::IRQ_OE_RST;
      IRQ_PIN_O <= ppaf_pkg::IRQ_PIN_RST;
      FAST_IRQ_IN_O <= ppaf_pkg::FAST_IRQ_RST;
      IRQ_DIR_O <= ppaf_pkg::IRQ_DIR_RST;
    end
    else
    begin
      IRQ_PAD_O <= next_irq_pad;
      IRQ_PAD_OE_O <= next_irq_oe;
      IRQ_PIN_O <= next_irq_pin;
      FAST_IRQ_IN_O <= next_fast_irq;
      IRQ_DIR_O <= next_irq_dir;
    end
  end

  // ------------------------------------------------------------
  // Timer-input port and count-direction routing
  // ------------------------------------------------------------
  logic [1:0] next_tin;
  logic next_tb, next_ta;

  // Input only: no driver and no direction bit exist for these pins.
  // The minimum build holds the direction inputs at zero (count up) rather
  // than leave the timers reading a pin that software may reuse.
  always_comb
  begin
    next_tin = TIN_PAD_I;
    next_tb = TIMER_ROUTE ? next_tin[ppaf_pkg::TIN_B_BIT] : 1'b0;
    next_ta = TIMER_ROUTE ? next_tin[ppaf_pkg::TIN_A_BIT] : 1'b0;
  end

  // Registered like the other ports, so both timers see one latency
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      TIN_PIN_O <= ppaf_pkg::TIN_PIN_RST;
      TIMER_B_UPDOWN_IN_O <= ppaf_pkg::UPDOWN_RST;
      TIMER_A_UPDOWN_IN_O <= ppaf_pkg::UPDOWN_RST;
    end
    else
    begin
      TIN_PIN_O <= next_tin;
      TIMER_B_UPDOWN_IN_O <= next_tb;
      TIMER_A_UPDOWN_IN_O <= next_ta;
    end
  end

endmodule

// ---- tb/ppaf_port_asserts.sv ----
// Checker for the port pin block, bound to every ppaf_port instance.
// Assumes the full variant: four selects, seven fast inputs, timer route.
`timescale 1ns/1ps
module ppaf_port_asserts (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Select port
  input wire logic SEL_DIR_WE_I,
  input wire logic [3:0] SEL_DIR_WDATA_I,
  input wire logic [3:0] SEL_ALT_EN_I,
  input wire logic [3:0] SEL_N_I,
  input wire logic [3:0] SEL_PAD_O,
  input wire logic [3:0] SEL_PAD_OE_O,
  input wire logic [3:0] SEL_DIR_O,
  // Interrupt and timer ports
  input wire logic [15:9] IRQ_PAD_I,
  input wire logic [15:9] IRQ_PAD_OE_O,
  input wire logic [6:0] IRQ_DIR_O,
  input wire logic [7:1] FAST_IRQ_IN_O,
  input wire logic [15:14] TIN_PAD_I,
  input wire logic [15:14] TIN_PIN_O,
  input wire logic TIMER_A_UPDOWN_IN_O,
  input wire logic TIMER_B_UPDOWN_IN_O
);
  logic live;
  // One edge of grace after reset, so $past never sees reset values
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I) live <= 1'b0;
    else live <= 1'b1;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_sel_dir_write: assert property (SEL_DIR_WE_I |=> SEL_DIR_O == $past(SEL_DIR_WDATA_I))
    else $error("select direction not written");
  a_sel_oe_dir: assert property (live |-> SEL_PAD_OE_O == ($past(SEL_DIR_O) | $past(SEL_ALT_EN_I)))
    else $error("select enable wrong");
  a_sel_alt_drive: assert property (live |-> ((SEL_PAD_O ^ $past(SEL_N_I)) & $past(SEL_ALT_EN_I)) == 4'h0)
    else $error("select pin not from select logic");
  a_irq_oe_dir: assert property (live |-> IRQ_PAD_OE_O == $past(IRQ_DIR_O))
    else $error("interrupt enable wrong");
  a_fast_irq_pad: assert property (1'b1 |=> FAST_IRQ_IN_O == $past(IRQ_PAD_I))
    else $error("fast input not from pad");
  a_tin_pin_sample: assert property (1'b1 |=> TIN_PIN_O == $past(TIN_PAD_I))
    else $error("timer pin not sampled");
  a_timer_b_dir: assert property (1'b1 ##1 1'b1 |-> TIMER_B_UPDOWN_IN_O == $past(TIN_PAD_I[14]))
    else $error("timer b direction wrong");
  a_timer_a_dir: assert property (1'b1 |=> TIMER_A_UPDOWN_IN_O == $past(TIN_PAD_I[15]))
    else $error("timer a direction wrong");
endmodule

bind ppaf_port ppaf_port_asserts chk (.*);

// ---- tb/ppaf_board.sv ----
// Board model: pads resolve to the device drive or to board levels.
// Assumes the bench sets the board levels anew in each random cycle.
`timescale 1ns/1ps
module ppaf_board (
  // Device drive
  input wire logic [3:0] sel_d_i,
  input wire logic [3:0] sel_oe_i,
  input wire logic [15:9] irq_d_i,
  input wire logic [15:9] irq_oe_i,
  // Board levels and resolved pads
  input wire logic [12:0] ext_i,
  output logic [3:0] sel_pad_o,
  output logic [15:9] irq_pad_o,
  output logic [15:14] tin_pad_o
);
  // Released pins show the board level, never a stale device value
  assign sel_pad_o = (sel_oe_i & sel_d_i) | (~sel_oe_i & ext_i[3:0]);
  assign irq_pad_o = (irq_oe_i & irq_d_i) | (~irq_oe_i & ext_i[10:4]);
  assign tin_pad_o = ext_i[12:11];
endmodule

// ---- tb/ppaf_port_test.sv ----
// Self-checking bench for the port pin block, full variant.
// Assumes the board model and checker from the same folder.
`timescale 1ns/1ps
module ppaf_port_test;
  logic clk = 0, rst = 1, sdwe = 0, sowe = 0, idwe = 0, iowe = 0, tma, tmb;
  logic [3:0] sdw = 0, sow = 0, alt = 0, seln = 4'hF, spad, spo, spoe, spin, sdir;
  logic [6:0] idw = 0, iow = 0, idir;
  logic [12:0] ext = 0;
  logic [15:9] ipad, ipo, ipoe, ipin;
  logic [7:1] fast;
  logic [15:14] tpad, tpin;
  int seed = 17347, n_fail = 0, n_compared = 0;
  // Bench copy of the latches, expected drive and pad levels before an edge
  logic [3:0] m_sdir, m_sout, e_spo, e_spoe, p_spad;
  logic [6:0] m_idir, m_iout, e_ipo, e_ipoe, p_ipad;
  logic [1:0] p_tpad;
  logic [31:0] r0, r1;
  always #2 clk = ~clk;
  ppaf_port dut (.CLK_I(clk), .RST_I(rst), .SEL_DIR_WDATA_I(sdw), .SEL_DIR_WE_I(sdwe),
    .SEL_OUT_WDATA_I(sow), .SEL_OUT_WE_I(sowe), .SEL_ALT_EN_I(alt), .SEL_N_I(seln),
    .SEL_PAD_I(spad), .SEL_PAD_O(spo), .SEL_PAD_OE_O(spoe), .SEL_PIN_O(spin),
    .IRQ_DIR_WDATA_I(idw), .IRQ_DIR_WE_I(idwe), .IRQ_OUT_WDATA_I(iow), .IRQ_OUT_WE_I(iowe),
    .IRQ_PAD_I(ipad), .IRQ_PAD_O(ipo), .IRQ_PAD_OE_O(ipoe), .IRQ_PIN_O(ipin),
    .FAST_IRQ_IN_O(fast), .TIN_PAD_I(tpad), .TIN_PIN_O(tpin), .TIMER_B_UPDOWN_IN_O(tmb),
    .TIMER_A_UPDOWN_IN_O(tma), .SEL_DIR_O(sdir), .IRQ_DIR_O(idir));
  ppaf_board board (.sel_d_i(spo), .sel_oe_i(spoe), .irq_d_i(ipo), .irq_oe_i(ipoe),
    .ext_i(ext), .sel_pad_o(spad), .irq_pad_o(ipad), .tin_pad_o(tpad));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      $display("ERROR %0t: got %h want %h", $time, seen, want);
      n_fail++;
    end
  endtask
  task conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  // Enable: direction bit, or forced on by a live select (all four built)
  function automatic logic [3:0] want_sel_oe(input logic [3:0] dir, input logic [3:0] en);
    return dir | en;
  endfunction
  // Pad value: select level where the alternate is on, else the latch
  function automatic logic [3:0] want_sel_pad(input logic [3:0] lat, input logic [3:0] en,
    input logic [3:0] sn);
    return (lat & ~en) | (sn & en);
  endfunction
  // Latches back to their values after reset
  task model_reset;
    m_sdir = ppaf_pkg::SEL_DIR_RST;
    m_sout = ppaf_pkg::SEL_OUT_RST;
    m_idir = ppaf_pkg::IRQ_DIR_RST;
    m_iout = ppaf_pkg::IRQ_OUT_RST;
  endtask
  // Random strobes, data, select controls and board levels
  task drive_random;
    r0 = $random(seed);
    r1 = $random(seed);
    {sdwe, sowe, idwe, iowe} = r0[3:0];
    sdw = r0[7:4];
    sow = r0[11:8];
    alt = r0[15:12];
    seln = r0[19:16];
    idw = r0[26:20];
    iow = r1[6:0];
    ext = r1[19:7];
  endtask
  // One clock with inputs already driven; every output checked after the edge
  task cycle;
    #1;
    p_spad = spad;
    p_ipad = ipad;
    p_tpad = tpad;
    e_spoe = want_sel_oe(m_sdir, alt);
    e_spo = want_sel_pad(m_sout, alt, seln);
    e_ipoe = m_idir;
    e_ipo = m_iout;
    if (sdwe) m_sdir = sdw;
    if (sowe) m_sout = sow;
    if (idwe) m_idir = idw;
    if (iowe) m_iout = iow;
    @(posedge clk);
    #1;
    check(sdir, m_sdir);
    check(idir, m_idir);
    check(spoe, e_spoe);
    check(spo, e_spo);
    check(ipoe, e_ipoe);
    check(ipo, e_ipo);
    check(spin, p_spad);
    check(ipin, p_ipad);
    check(fast, p_ipad);
    check(tpin, p_tpad);
    check(tmb, p_tpad[0]);
    check(tma, p_tpad[1]);
  endtask
  // Random traffic, then held corner values, then a reset in mid-run
  initial
  begin
    model_reset;
    repeat (5) step;
    rst = 0;
    repeat (200)
    begin
      drive_random;
      cycle;
    end
    // Corner: direction writes with one live select and a fixed board pattern
    {sowe, iowe} = 2'b00;
    {sdwe, sdw, alt, seln, idwe, idw, ext} = {1'b1, 4'hA, 4'h4, 4'hB, 1'b1, 7'h00, 13'h0ABC};
    cycle;
    {sdwe, idwe} = 2'b00;
    check(sdir, 4'hA);
    check(idir, 7'h00);
    repeat (2) cycle;
    check(spoe, 4'hE);
    check(spo[2], seln[2]);
    check(ipoe, 7'h00);
    check(fast, ext[10:4]);
    check({tma, tmb}, ext[12:11]);
    check(tmb, ext[11]);
    check(tpin, ext[12:11]);
    // Reset in mid-run: drivers off at once, latches restart
    rst = 1;
    #1;
    check({spoe, spo}, 8'h0F);
    check(ipoe, 7'h00);
    check(ipo, ppaf_pkg::IRQ_OUT_RST);
    check(sdir, ppaf_pkg::SEL_DIR_RST);
    check(idir, ppaf_pkg::IRQ_DIR_RST);
    step;
    rst = 0;
    model_reset;
    repeat (40)
    begin
      drive_random;
      cycle;
    end
    conclude;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #4000;
    n_fail++;
    conclude;
  end
endmodule
